// >>> rdrv_pkg.sv
// package of register map constants and carrier types for the redriver bank
package rdrv_pkg;

  // ---------------------------------------------------------------------------
  // secondary address straps (five-level pins coded 0..4, 4 = floating)
  // ---------------------------------------------------------------------------
  localparam logic [2:0] LVL_FLOAT    = 3'h4;
  localparam logic [2:0] LVL_L2       = 3'h2;
  localparam logic [2:0] LVL_L3       = 3'h3;
  localparam logic [6:0] ADDR_L2_L2   = 7'h2C;
  localparam logic [6:0] ADDR_L3_BASE = 7'h30;
  localparam logic [6:0] ADDR_NONE    = 7'h00;
  localparam logic [2:0] MODE_SECONDARY = 3'h2;

  // ---------------------------------------------------------------------------
  // window decode of the 8-bit register space
  // ---------------------------------------------------------------------------
  localparam logic [2:0] WIN_CH0     = 3'h0;
  localparam logic [2:0] WIN_CH1     = 3'h1;
  localparam logic [2:0] WIN_CH2     = 3'h2;
  localparam logic [2:0] WIN_CH3     = 3'h3;
  localparam logic [2:0] WIN_BC_ALL  = 3'h4;
  localparam logic [2:0] WIN_BC_01   = 3'h5;
  localparam logic [2:0] WIN_BC_23   = 3'h6;
  localparam logic [2:0] WIN_SHARED  = 3'h7;

  // channel window offsets
  localparam logic [4:0] OFS_BOOST   = 5'h01;
  localparam logic [4:0] OFS_PROFILE = 5'h03;
  localparam logic [4:0] OFS_TEST    = 5'h04;

  // shared register addresses
  localparam logic [7:0] ADR_RESET_LOAD = 8'hE2;
  localparam logic [7:0] ADR_LOAD_STAT  = 8'hE3;
  localparam logic [7:0] ADR_IDENT_LOW  = 8'hF0;
  localparam logic [7:0] ADR_IDENT_HIGH = 8'hF1;

  // control bits of the reset/load register
  localparam int BIT_SOFT_RESET   = 6;
  localparam int BIT_LOADER_RESET = 5;
  localparam int BIT_FORCE_LOAD   = 0;

  // field masks and reset values
  localparam logic [7:0] BOOST_MASK    = 8'hFF;
  localparam logic [7:0] BOOST_RESET   = 8'h00;
  localparam logic [7:0] PROFILE_MASK  = 8'h7F;
  localparam logic [7:0] PROFILE_RESET = 8'h05;
  localparam logic [7:0] TEST_MASK     = 8'h04;
  localparam logic [7:0] TEST_RESET    = 8'h00;
  localparam logic [7:0] IDENT_LOW_MASK = 8'h0E;

  // i2c timing: 20 MHz clock, 400 kHz bus
  localparam int CLK_HZ     = 20000000;
  localparam int BUS_MAX_HZ = 400000;
  localparam int CLK_PER_SCL = CLK_HZ / BUS_MAX_HZ;

  // per-channel settings
  typedef struct packed {
    logic [7:0] boost;
    logic [7:0] profile;
    logic [7:0] test;
  } rdrv_chan_type;

  // loader status from the configuration loader
  typedef struct packed {
    logic       done;
    logic       fail;
    logic [1:0] tries;
  } rdrv_load_type;

endpackage

// >>> rdrv_i2c_slave.sv
// i2c secondary byte engine: address match, register pointer, read and write
`timescale 1ns/100ps
module rdrv_i2c_slave (
  input  wire logic       sys_clk,   // system clock
  input  wire logic       rst_b,     // async reset, active low
  input  wire logic       sclIn,     // synchronised scl
  input  wire logic       sdaIn,     // synchronised sda
  input  wire logic       enable,    // secondary mode selected
  input  wire logic [6:0] myAddr,    // own address, zero when none
  input  wire logic [7:0] rdData,    // read data for regAddr
  output logic            sdaOe,     // pull sda low
  output logic            wrStb,     // one-cycle write strobe
  output logic [7:0]      regAddr,   // register pointer
  output logic [7:0]      wrData     // write data
);

  // ---------------------------------------------------------------------------
  // bus condition detect
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_ADDR = 3'h1, S_AACK = 3'h3, S_PTR = 3'h2,
    S_WDAT = 3'h4, S_RDAT = 3'h7, S_RACK = 3'h5, S_DACK = 3'h6
  } rdrv_i2c_state_type;

  rdrv_i2c_state_type state_q;
  logic        sclD_q, sdaD_q;
  logic [7:0]  shift_q;
  logic [3:0]  bitCnt_q;
  logic        rnw_q;
  logic        sclRise, sclFall, start, stop;

  assign sclRise = sclIn & ~sclD_q;
  assign sclFall = ~sclIn & sclD_q;
  assign start   = sclIn & sclD_q & sdaD_q & ~sdaIn;
  assign stop    = sclIn & sclD_q & ~sdaD_q & sdaIn;

  // edge history
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclD_q <= 1'b1;
      sdaD_q <= 1'b1;
    end else begin
      sclD_q <= sclIn;
      sdaD_q <= sdaIn;
    end
  end

  // ---------------------------------------------------------------------------
  // protocol state machine
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= S_IDLE;
      shift_q   <= 8'h00;
      bitCnt_q  <= 4'h0;
      rnw_q     <= 1'b0;
      sdaOe     <= 1'b0;
      wrStb     <= 1'b0;
      regAddr   <= 8'h00;
      wrData    <= 8'h00;
    end else begin
      wrStb <= 1'b0;
      if (!enable || stop) begin
        state_q <= S_IDLE;
        sdaOe   <= 1'b0;
      end else if (start) begin
        state_q  <= S_ADDR;
        bitCnt_q <= 4'h0;
        sdaOe    <= 1'b0;
      end else begin
        case (state_q)
          S_IDLE: begin
            sdaOe <= 1'b0;
          end
          S_ADDR, S_PTR, S_WDAT: begin
            if (sclRise) begin
              shift_q  <= {shift_q[6:0], sdaIn};
              bitCnt_q <= bitCnt_q + 4'h1;
            end
            if (sclFall && bitCnt_q == 4'h8) begin
              bitCnt_q <= 4'h0;
              if (state_q == S_ADDR) begin
                if (myAddr != 7'h00 && shift_q[7:1] == myAddr) begin
                  rnw_q     <= shift_q[0];
                  sdaOe     <= 1'b1;
                  state_q   <= S_AACK;
                end else begin
                  state_q <= S_IDLE;
                end
              end else if (state_q == S_PTR) begin
                regAddr   <= shift_q;
                sdaOe     <= 1'b1;
                state_q   <= S_DACK;
              end else begin
                wrData  <= shift_q;
                wrStb   <= 1'b1;
                sdaOe   <= 1'b1;
                state_q <= S_DACK;
              end
            end
          end
          S_AACK: begin
            if (sclFall) begin
              if (rnw_q) begin
                shift_q <= rdData;
                sdaOe   <= ~rdData[7];
                state_q <= S_RDAT;
              end else begin
                sdaOe   <= 1'b0;
                state_q <= S_PTR;
              end
            end
          end
          S_DACK: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              state_q <= S_WDAT;
            end
          end
          S_RDAT: begin
            if (sclFall) begin
              bitCnt_q <= bitCnt_q + 4'h1;
              if (bitCnt_q == 4'h7) begin
                sdaOe   <= 1'b0;
                state_q <= S_RACK;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                sdaOe   <= ~shift_q[6];
              end
            end
          end
          S_RACK: begin
            if (sclRise) begin
              regAddr <= regAddr + 8'h01;
              state_q <= sdaIn ? S_IDLE : S_AACK;
              bitCnt_q <= 4'h0;
            end
          end
          default: state_q <= S_IDLE;
        endcase
        // pointer advances after each written data byte
        if (wrStb) begin
          regAddr <= regAddr + 8'h01;
        end
      end
    end
  end

endmodule

// >>> rdrv_register_map.sv
// top of the redriver register bank behind the i2c secondary port
`timescale 1ns/100ps
module rdrv_register_map #(
  parameter logic [2:0] IDENT_LOW_CODE  = 3'h5, // arbitrary value
  parameter logic [7:0] IDENT_HIGH_CODE = 8'hA5 // arbitrary value
) (
  input  wire logic                   sys_clk,       // 20 MHz clock
  input  wire logic                   rst_b,         // async reset, low
  input  wire logic                   sclPin,        // scl from pin
  input  wire logic                   sdaPin,        // sda from pin
  output logic                        sdaOut,        // sda drive value
  output logic                        sdaOe,         // sda drive enable
  input  wire logic [2:0]             addr_strap_hi, // high address strap
  input  wire logic [2:0]             addr_strap_lo, // low address strap
  input  wire logic [2:0]             modeStrap,     // mode strap level
  input  wire rdrv_pkg::rdrv_load_type loadStatA,    // loader status set a
  input  wire rdrv_pkg::rdrv_load_type loadStatB,    // loader status set b
  output logic                        loaderReset,   // loader reset pulse
  output logic                        forceLoad,     // forced load pulse
  output rdrv_pkg::rdrv_chan_type     chanCfg [4]    // channel settings
);

  // ---------------------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------------------
  // the two-flop pin path needs several clocks in every bus phase
  if (rdrv_pkg::CLK_PER_SCL < 8) begin : g_chk
    $error("system clock too slow for the bus rate");
  end

  // shared registers must decode inside the shared window
  if (rdrv_pkg::ADR_RESET_LOAD[7:5] != rdrv_pkg::WIN_SHARED
      || rdrv_pkg::ADR_LOAD_STAT[7:5] != rdrv_pkg::WIN_SHARED
      || rdrv_pkg::ADR_IDENT_LOW[7:5] != rdrv_pkg::WIN_SHARED
      || rdrv_pkg::ADR_IDENT_HIGH[7:5] != rdrv_pkg::WIN_SHARED) begin : g_win
    $error("shared register outside the shared window");
  end

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] sclSync_q, sdaSync_q;
  logic [2:0] modeS1_q, modeS2_q, hiS1_q, hiS2_q, loS1_q, loS2_q;

  // two flops on every pin input
  // scl and sda idle high, so their flops reset to one: no false edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      modeS1_q  <= 3'h0;
      modeS2_q  <= 3'h0;
      hiS1_q    <= 3'h0;
      hiS2_q    <= 3'h0;
      loS1_q    <= 3'h0;
      loS2_q    <= 3'h0;
    end else begin
      sclSync_q <= {sclSync_q[0], sclPin};
      sdaSync_q <= {sdaSync_q[0], sdaPin};
      modeS1_q  <= modeStrap;
      modeS2_q  <= modeS1_q;
      hiS1_q    <= addr_strap_hi;
      hiS2_q    <= hiS1_q;
      loS1_q    <= addr_strap_lo;
      loS2_q    <= loS1_q;
    end
  end

  // ---------------------------------------------------------------------------
  // address selection from straps
  // ---------------------------------------------------------------------------
  // reserved or floating strap combinations give address zero: no answer
  function automatic logic [6:0] strapAddr(input logic [2:0] hi,
                                           input logic [2:0] lo);
    logic [6:0] a;
    a = rdrv_pkg::ADDR_NONE;
    if (hi == rdrv_pkg::LVL_L2 && lo == rdrv_pkg::LVL_L2) begin
      a = rdrv_pkg::ADDR_L2_L2;
    end else if (hi == rdrv_pkg::LVL_L3 && lo != rdrv_pkg::LVL_FLOAT
                 && lo < rdrv_pkg::LVL_FLOAT) begin
      a = rdrv_pkg::ADDR_L3_BASE + {3'h0, lo[1:0], 1'b0};
    end
    return a;
  endfunction

  logic [6:0] myAddr;
  logic       secEnable;
  assign myAddr    = strapAddr(hiS2_q, loS2_q);
  assign secEnable = (modeS2_q == rdrv_pkg::MODE_SECONDARY);

  // ---------------------------------------------------------------------------
  // bus engine
  // ---------------------------------------------------------------------------
  logic       wrStb, engOe;
  logic [7:0] regAddr, wrData, rdData;

  rdrv_i2c_slave u_slave (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .sclIn   (sclSync_q[1]),
    .sdaIn   (sdaSync_q[1]),
    .enable  (secEnable),
    .myAddr  (myAddr),
    .rdData  (rdData),
    .sdaOe   (engOe),
    .wrStb   (wrStb),
    .regAddr (regAddr),
    .wrData  (wrData)
  );

  // open drain: drive low only
  // the extra flop adds one cycle of ack delay; bus phases leave margin
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdaOe  <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      sdaOe  <= engOe;
      sdaOut <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // window decode
  // ---------------------------------------------------------------------------
  // per-channel write enables; broadcast windows set several bits
  function automatic logic [3:0] writeSel(input logic [2:0] win);
    logic [3:0] s;
    s = 4'h0;
    case (win)
      rdrv_pkg::WIN_CH0:    s = 4'h1;
      rdrv_pkg::WIN_CH1:    s = 4'h2;
      rdrv_pkg::WIN_CH2:    s = 4'h4;
      rdrv_pkg::WIN_CH3:    s = 4'h8;
      rdrv_pkg::WIN_BC_ALL: s = 4'hF;
      rdrv_pkg::WIN_BC_01:  s = 4'h3;
      rdrv_pkg::WIN_BC_23:  s = 4'hC;
      default:              s = 4'h0;
    endcase
    return s;
  endfunction

  // broadcast windows read back one representative channel
  function automatic logic [1:0] readSel(input logic [2:0] win);
    logic [1:0] c;
    c = 2'h0;
    case (win)
      rdrv_pkg::WIN_CH1:   c = 2'h1;
      rdrv_pkg::WIN_CH2:   c = 2'h2;
      rdrv_pkg::WIN_CH3:   c = 2'h3;
      rdrv_pkg::WIN_BC_23: c = 2'h2;
      rdrv_pkg::WIN_BC_ALL: c = 2'h0;
      rdrv_pkg::WIN_BC_01: c = 2'h0;
      default:             c = 2'h0;
    endcase
    return c;
  endfunction

  // one control bit written to the reset/load register in this cycle
  function automatic logic ctrlBit(input logic       stb,
                                   input logic [7:0] a,
                                   input logic [7:0] d,
                                   input int         b);
    logic hit;
    hit = stb && a == rdrv_pkg::ADR_RESET_LOAD && d[b];
    return hit;
  endfunction

  logic [2:0] win;
  logic [4:0] ofs;
  logic       softReset;
  assign win = regAddr[7:5];
  assign ofs = regAddr[4:0];
  assign softReset = ctrlBit(wrStb, regAddr, wrData,
                             rdrv_pkg::BIT_SOFT_RESET);

  // ---------------------------------------------------------------------------
  // channel registers
  // ---------------------------------------------------------------------------
  rdrv_pkg::rdrv_chan_type chan_q [4];
  logic [3:0] sel;
  assign sel = writeSel(win);

  // masked writes per channel, soft reset restores defaults
  // soft reset outranks a data write landing in the same cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        chan_q[i].boost   <= rdrv_pkg::BOOST_RESET;
        chan_q[i].profile <= rdrv_pkg::PROFILE_RESET;
        chan_q[i].test    <= rdrv_pkg::TEST_RESET;
      end
    end else if (softReset) begin
      for (int i = 0; i < 4; i++) begin
        chan_q[i].boost   <= rdrv_pkg::BOOST_RESET;
        chan_q[i].profile <= rdrv_pkg::PROFILE_RESET;
        chan_q[i].test    <= rdrv_pkg::TEST_RESET;
      end
    end else if (wrStb) begin
      for (int i = 0; i < 4; i++) begin
        if (sel[i]) begin
          case (ofs)
            rdrv_pkg::OFS_BOOST:
              chan_q[i].boost <= wrData & rdrv_pkg::BOOST_MASK;
            rdrv_pkg::OFS_PROFILE:
              chan_q[i].profile <= wrData & rdrv_pkg::PROFILE_MASK;
            rdrv_pkg::OFS_TEST:
              chan_q[i].test <= wrData & rdrv_pkg::TEST_MASK;
            default: chan_q[i].boost <= chan_q[i].boost;
          endcase
        end
      end
    end
  end

  // registered copies for the outputs
  // outputs trail the internal registers by one cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        chanCfg[i] <= {rdrv_pkg::BOOST_RESET, rdrv_pkg::PROFILE_RESET,
                       rdrv_pkg::TEST_RESET};
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        chanCfg[i] <= chan_q[i];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // shared control: self-clearing pulses
  // each pulse lasts one cycle; no control bit is stored
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      loaderReset <= 1'b0;
      forceLoad   <= 1'b0;
    end else begin
      loaderReset <= ctrlBit(wrStb, regAddr, wrData,
                             rdrv_pkg::BIT_LOADER_RESET);
      forceLoad   <= ctrlBit(wrStb, regAddr, wrData,
                             rdrv_pkg::BIT_FORCE_LOAD);
    end
  end

  // ---------------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] chanRead(input rdrv_pkg::rdrv_chan_type c,
                                          input logic [4:0] o);
    logic [7:0] r;
    r = 8'h00;
    case (o)
      rdrv_pkg::OFS_BOOST:   r = c.boost;
      rdrv_pkg::OFS_PROFILE: r = c.profile & rdrv_pkg::PROFILE_MASK;
      rdrv_pkg::OFS_TEST:    r = c.test & rdrv_pkg::TEST_MASK;
      default:               r = 8'h00;
    endcase
    return r;
  endfunction

  // shared window reads; self-clearing bits read zero
  // combinational on the pointer; the engine loads it at the ack edge
  always_comb begin
    rdData = 8'h00;
    if (win == rdrv_pkg::WIN_SHARED) begin
      case (regAddr)
        rdrv_pkg::ADR_RESET_LOAD: rdData = 8'h00;
        rdrv_pkg::ADR_LOAD_STAT:
          rdData = {loadStatA, loadStatB};
        rdrv_pkg::ADR_IDENT_LOW:
          rdData = {4'h0, IDENT_LOW_CODE, 1'b0};
        rdrv_pkg::ADR_IDENT_HIGH:
          rdData = IDENT_HIGH_CODE;
        default: rdData = 8'h00;
      endcase
    end else begin
      rdData = chanRead(chan_q[readSel(win)], ofs);
    end
  end

endmodule

// >>> rdrv_register_map_chk.sv
// port checker for the redriver register bank
`timescale 1ns/100ps
module rdrv_register_map_chk (
  input wire logic                    sys_clk,       // system clock
  input wire logic                    rst_b,         // async reset, low
  input wire logic                    sclPin,        // scl from pin
  input wire logic                    sdaOut,        // sda drive value
  input wire logic                    sdaOe,         // sda drive enable
  input wire logic [2:0]              addr_strap_hi, // high address strap
  input wire logic [2:0]              addr_strap_lo, // low address strap
  input wire logic [2:0]              modeStrap,     // mode strap level
  input wire logic                    loaderReset,   // loader reset pulse
  input wire logic                    forceLoad,     // forced load pulse
  input wire rdrv_pkg::rdrv_chan_type chanCfg [4]    // channel settings
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // pulse that drops after one cycle, and a level held for eight cycles
  sequence s_one_shot(p);
    p ##1 !p;
  endsequence
  sequence s_quiet(c);
    c [*8];
  endsequence

  chk_sda_value: assert property (sdaOut == 1'b0)
    else $error("sda drive value not low");
  chk_ack_scl_low: assert property ($changed(sdaOe) |-> !sclPin)
    else $error("sda drive changed while scl high");
  chk_mode_gate: assert property (
    s_quiet(modeStrap != 3'h2) |-> !sdaOe)
    else $error("sda driven outside secondary mode");
  chk_strap_float: assert property (
    s_quiet(addr_strap_hi == 3'h4 || addr_strap_lo == 3'h4) |-> !sdaOe)
    else $error("sda driven with reserved strap");
  chk_reset_values: assert property ($rose(rst_b) |->
    chanCfg[0] == 24'h000500 && chanCfg[3] == 24'h000500)
    else $error("channel settings not at defaults after reset");
  chk_loader_pulse: assert property (
    $rose(loaderReset) |-> s_one_shot(loaderReset))
    else $error("loader reset pulse longer than one cycle");
  chk_force_pulse: assert property (
    $rose(forceLoad) |-> s_one_shot(forceLoad))
    else $error("forced load pulse longer than one cycle");
  chk_profile_rsvd: assert property (((chanCfg[0].profile |
    chanCfg[1].profile | chanCfg[2].profile | chanCfg[3].profile)
    & 8'h80) == 8'h00)
    else $error("profile bit 7 set");
  chk_test_rsvd: assert property (((chanCfg[0].test |
    chanCfg[1].test | chanCfg[2].test | chanCfg[3].test) & 8'hFB) == 8'h00)
    else $error("reserved test bits set");
endmodule

bind rdrv_register_map rdrv_register_map_chk chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .sclPin(sclPin), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .addr_strap_hi(addr_strap_hi),
  .addr_strap_lo(addr_strap_lo), .modeStrap(modeStrap),
  .loaderReset(loaderReset), .forceLoad(forceLoad), .chanCfg(chanCfg)
);

// >>> rdrv_i2c_host.sv
// behavioural i2c host driving scl and sda of the register bank
`timescale 1ns/100ps
module rdrv_i2c_host (
  input  wire logic sys_clk,  // system clock
  input  wire logic devSdaOe, // device pulls sda low
  output logic      sclLine,  // scl wire level
  output logic      sdaLine   // sda wire level with pull-up
);
  logic sdaDrvLow; // host pulls sda low

  // open-drain wire, pulled up when nobody drives
  assign sdaLine = ~(sdaDrvLow | devSdaOe);

  // bus starts idle
  initial begin
    sclLine = 1'b1;
    sdaDrvLow = 1'b0;
  end

  // quarter bit: 52 clocks a bit keeps scl under 400 kHz
  task automatic quarter();
    repeat (13) @(negedge sys_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    quarter();
    sdaDrvLow = ~b;
    quarter();
    sclLine = 1'b1;
    quarter();
    r = sdaLine;
    quarter();
    sclLine = 1'b0;
  endtask
  task automatic start();
    sdaDrvLow = 1'b0;
    quarter();
    sclLine = 1'b1;
    quarter();
    sdaDrvLow = 1'b1;
    quarter();
    sclLine = 1'b0;
  endtask
  task automatic stop();
    quarter();
    sdaDrvLow = 1'b1;
    quarter();
    sclLine = 1'b1;
    quarter();
    sdaDrvLow = 1'b0;
    quarter();
  endtask
  // one byte msb first, then the acknowledge bit given by last
  task automatic xfer(input logic [7:0] tx, input logic last,
                      output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(last, r);
    ack = ~r;
  endtask
  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ra,
                        input logic [7:0] wd, output logic ack);
    logic [7:0] rx;
    logic       a;
    start();
    xfer({dev, 1'b0}, 1'b1, rx, ack);
    xfer(ra, 1'b1, rx, a);
    xfer(wd, 1'b1, rx, a);
    stop();
  endtask
  task automatic rd_reg(input logic [6:0] dev, input logic [7:0] ra,
                        output logic [7:0] rd, output logic ack);
    logic [7:0] rx;
    logic       a;
    start();
    xfer({dev, 1'b0}, 1'b1, rx, ack);
    xfer(ra, 1'b1, rx, a);
    start();
    xfer({dev, 1'b1}, 1'b1, rx, a);
    xfer(8'hFF, 1'b1, rd, a);
    stop();
  endtask
endmodule

// >>> rdrv_register_map_tb.sv
// self-checking bench for the redriver register bank
`timescale 1ns/100ps
module rdrv_register_map_tb;
  localparam logic [2:0] IDL = 3'h6;  // arbitrary value
  localparam logic [7:0] IDH = 8'h3C; // arbitrary value
  localparam logic [6:0] DEV = 7'h32; // strap high L3, low L1
  logic                    sys_clk, rst_b, sclPin, sdaPin, sdaOut, sdaOe;
  logic                    loaderReset, forceLoad, ack;
  logic [2:0]              strapHi, strapLo, modeStrap;
  logic [7:0]              rd;
  rdrv_pkg::rdrv_load_type loadStatA, loadStatB;
  rdrv_pkg::rdrv_chan_type chanCfg [4];
  int                      err_total = 0, compares = 0, ldCnt = 0, flCnt = 0;
  logic [2:0]              hiT [5] = '{3'h2, 3'h3, 3'h3, 3'h3, 3'h3};
  logic [2:0]              loT [5] = '{3'h2, 3'h0, 3'h1, 3'h2, 3'h3};
  logic [6:0]              adT [5] = '{7'h2C, 7'h30, 7'h32, 7'h34, 7'h36};

  rdrv_register_map #(.IDENT_LOW_CODE(IDL), .IDENT_HIGH_CODE(IDH)) uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .sclPin(sclPin), .sdaPin(sdaPin),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_strap_hi(strapHi),
    .addr_strap_lo(strapLo), .modeStrap(modeStrap), .loadStatA(loadStatA),
    .loadStatB(loadStatB), .loaderReset(loaderReset),
    .forceLoad(forceLoad), .chanCfg(chanCfg));
  rdrv_i2c_host host (.sys_clk(sys_clk), .devSdaOe(sdaOe),
    .sclLine(sclPin), .sdaLine(sdaPin));

  // 50 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // count loader pulses
  always @(negedge sys_clk) begin
    if (loaderReset === 1'b1) ldCnt++;
    if (forceLoad === 1'b1) flCnt++;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk_cfg(input logic [23:0] c0, c1, c2, c3);
    check(chanCfg[0], c0);
    check(chanCfg[1], c1);
    check(chanCfg[2], c2);
    check(chanCfg[3], c3);
  endtask
  task automatic give_verdict();
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog against a hung bus
  initial begin
    repeat (80000) @(posedge sys_clk);
    err_total++;
    give_verdict();
  end

  // ---------------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    strapHi = 3'h3;
    strapLo = 3'h1;
    modeStrap = 3'h2;
    loadStatA = 4'h0;
    loadStatB = 4'h0;
    repeat (3) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk_cfg(24'h000500, 24'h000500, 24'h000500, 24'h000500);
    for (int i = 0; i < 5; i++) begin
      strapHi = hiT[i];
      strapLo = loT[i];
      repeat (4) @(negedge sys_clk);
      host.rd_reg(adT[i], 8'hF1, rd, ack);
      check(24'(ack), 24'h1);
      check(24'(rd), 24'(IDH));
    end
    strapLo = 3'h4;
    repeat (4) @(negedge sys_clk);
    host.rd_reg(7'h36, 8'hF1, rd, ack);
    check(24'(ack), 24'h0);
    strapLo = 3'h1;
    modeStrap = 3'h1;
    repeat (4) @(negedge sys_clk);
    host.rd_reg(DEV, 8'hF1, rd, ack);
    check(24'(ack), 24'h0);
    modeStrap = 3'h2;
    repeat (4) @(negedge sys_clk);
    host.rd_reg(DEV, 8'hF0, rd, ack);
    check(24'(rd), 24'({4'h0, IDL, 1'b0}));
    for (int i = 0; i < 4; i++) begin
      host.wr_reg(DEV, 8'(32 * i + 1), 8'(8'h11 * (i + 1)), ack);
      host.rd_reg(DEV, 8'(32 * i + 1), rd, ack);
      check(24'(rd), 24'(8'(8'h11 * (i + 1))));
    end
    chk_cfg(24'h110500, 24'h220500, 24'h330500, 24'h440500);
    host.wr_reg(DEV, 8'h81, 8'hA7, ack);
    host.wr_reg(DEV, 8'hA3, 8'hFF, ack);
    host.wr_reg(DEV, 8'hC4, 8'hFF, ack);
    host.wr_reg(DEV, 8'h04, 8'h04, ack);
    host.wr_reg(DEV, 8'h02, 8'hFF, ack);
    chk_cfg(24'hA77F04, 24'hA77F00, 24'hA70504, 24'hA70504);
    host.rd_reg(DEV, 8'h83, rd, ack);
    check(24'(rd), 24'h00007F);
    host.rd_reg(DEV, 8'hA4, rd, ack);
    check(24'(rd), 24'h000004);
    host.rd_reg(DEV, 8'hC3, rd, ack);
    check(24'(rd), 24'h000005);
    host.rd_reg(DEV, 8'h02, rd, ack);
    check(24'(rd), 24'h000000);
    loadStatA = 4'hD;
    loadStatB = 4'h2;
    host.rd_reg(DEV, 8'hE3, rd, ack);
    check(24'(rd), 24'h0000D2);
    host.wr_reg(DEV, 8'hE2, 8'h21, ack);
    check(24'(ldCnt), 24'h1);
    check(24'(flCnt), 24'h1);
    host.rd_reg(DEV, 8'hE2, rd, ack);
    check(24'(rd), 24'h000000);
    host.wr_reg(DEV, 8'hE2, 8'h40, ack);
    chk_cfg(24'h000500, 24'h000500, 24'h000500, 24'h000500);
    give_verdict();
  end
endmodule
